// ==== design/rmcm_pkg.sv ====
/*
 * constants, symbol and pattern types for the receive rate-match
 * sequence matcher and elastic buffer.
 * assumes one core clock; the link symbol clock is sampled, not used.
 */
package rmcm_pkg;

	localparam int          SYM_W       = 8;
	localparam int          SEQ_MAX     = 4;
	localparam int          BUF_AW      = 5;
	localparam logic [5:0]  BUF_DEPTH   = 6'h20;
	localparam logic [5:0]  BUF_NOMINAL = 6'h10;
	localparam logic [2:0]  HIST_FULL   = 3'h4;
	// largest net bonding slip, in characters, either way
	localparam logic signed [3:0] SKEW_MAX = 4'sh7;
	localparam logic signed [3:0] SKEW_MIN = -4'sh7;
	// reference single-symbol patterns, both control characters
	localparam logic [7:0]  REF_BOND_SYM = 8'h7c; // [RULE_05]
	localparam logic [7:0]  REF_RMC_SYM  = 8'h1c; // [RULE_06]
	localparam logic [1:0]  REF_SEQ_LEN  = 2'h0;

	// decoded receive symbol
	typedef struct packed {
		logic [SYM_W-1:0] data;
		logic             is_k;
		logic             disp_inv;
	} rmcm_sym_t;

	// one position of a sequence definition
	typedef struct packed {
		logic [SYM_W-1:0] data;
		logic             is_k;
		logic             inv_ok;
		logic             wild;
	} rmcm_pat_t;

	typedef rmcm_pat_t [SEQ_MAX-1:0] rmcm_seq_t;

	localparam int SYM_BITS = $bits(rmcm_sym_t);

endpackage : rmcm_pkg

// ==== design/rmcm_mem.sv ====
/*
 * simple dual-port buffer memory with registered read data.
 * assumes one clock for both ports; write and read may hit one address.
 */
`timescale 1ns/1ps
module rmcm_mem #(
	parameter int W  = 10,
	parameter int AW = 5
) (
	input  wire logic          clock,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge clock)
	begin
		if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule : rmcm_mem

// ==== design/rmcm_top.sv ====
/*
 * receive rate-match sequence matcher with elastic buffer and
 * bonding-sequence slip. symbols arrive with a slow link clock that is
 * sampled by the core clock; the user drains the buffer with valid/ready.
 * assumes link clock slower than a fifth of the core clock.
 */
// Behaviour
// [RULE_01] rate-match sequence seen: add or drop characters
// [RULE_02] sequence length configurable, one symbol allowed
// [RULE_03] optional second sequence also triggers correction
// [RULE_04] each position compares an 8-bit decoded value
// [RULE_05] reference bonding symbol 0x7c as control
// [RULE_06] reference rate-match symbol 0x1c as control
// [RULE_07] length one disables the other positions
// [RULE_08] control flag requires decoded control character
// [RULE_09] inverted-disparity option accepts inverted symbols
// [RULE_10] wildcard position accepts any symbol
// [RULE_11] positions past length act as wildcards
// [RULE_12] far end sends sequences at regular intervals
// [RULE_13] optional second bonding sequence also triggers
// [RULE_14] bonding sequence: add or drop for alignment
// [RULE_15] bonding skew kept within seven characters
// [RULE_16] drop above nominal, repeat below, else unchanged
// [RULE_17] only whole sequences are added or dropped
`timescale 1ns/1ps
module rmcm_top
	import rmcm_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                reset_n,
	input  wire logic                link_clk,
	input  wire rmcm_pkg::rmcm_sym_t link_sym,
	input  wire logic                rmc_en,
	input  wire logic                rmc_two_en,
	input  wire logic [1:0]          rmc_len,
	input  wire rmcm_pkg::rmcm_seq_t rmc_seq_a,
	input  wire rmcm_pkg::rmcm_seq_t rmc_seq_b,
	input  wire logic                bond_en,
	input  wire logic                bond_two_en,
	input  wire logic [1:0]          bond_len,
	input  wire rmcm_pkg::rmcm_seq_t bond_seq_a,
	input  wire rmcm_pkg::rmcm_seq_t bond_seq_b,
	input  wire logic                bond_slip_req,
	input  wire logic                bond_slip_remove,
	input  wire logic                rd_ready,
	output logic                     rd_valid,
	output rmcm_pkg::rmcm_sym_t      rd_sym,
	output logic [5:0]               occupancy,
	output logic                     rmc_removed,
	output logic                     rmc_inserted,
	output logic                     bond_match,
	output logic signed [3:0]        bond_skew,
	output logic                     overflow
);
	import rmcm_pkg::*;

	// position i of a sequence meets history entry len-i (0 newest)
	function automatic logic seq_hit(input rmcm_seq_t p,
		input logic [1:0] len, input rmcm_sym_t [3:0] h);
		logic      ok;
		logic [1:0] idx;
		ok = 1'b1;
		for (int i = 0; i < SEQ_MAX; i++)
		begin
			idx = 2'(int'(len) - i);
			if (i <= int'(len) && !p[i].wild) // [RULE_07] [RULE_10] [RULE_11]
			begin
				if (p[i].data != h[idx].data) // [RULE_04]
					ok = 1'b0;
				if (p[i].is_k != h[idx].is_k) // [RULE_08]
					ok = 1'b0;
				if (h[idx].disp_inv && !p[i].inv_ok) // [RULE_09]
					ok = 1'b0;
			end
		end
		return ok;
	endfunction : seq_hit

	// link sampling
	logic      lclk_s1_r, lclk_s2_r, lclk_s3_r;
	rmcm_sym_t sym_s1_r, sym_s2_r;

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			lclk_s1_r <= 1'b0;
			lclk_s2_r <= 1'b0;
			lclk_s3_r <= 1'b0;
			sym_s1_r  <= '0;
			sym_s2_r  <= '0;
		end
		else
		begin
			lclk_s1_r <= link_clk;
			lclk_s2_r <= lclk_s1_r;
			lclk_s3_r <= lclk_s2_r;
			sym_s1_r  <= link_sym;
			sym_s2_r  <= sym_s1_r;
		end
	end

	wire ev = lclk_s2_r & ~lclk_s3_r;

	// state
	rmcm_sym_t [3:0]   hist_r;
	logic [2:0]        hist_cnt_r, rep_cnt_r;
	logic [5:0]        wptr_r, rptr_r;
	logic              out_valid_r;
	logic signed [3:0] skew_r;
	logic [5:0]        occ_r;

	wire rmcm_sym_t [3:0] hist_nxt = {hist_r[2:0], sym_s2_r};
	wire [5:0] occ   = 6'(wptr_r - rptr_r);
	wire       full  = (occ == BUF_DEPTH);
	wire       empty = (occ == 6'h00);

	// matching
	wire hit_a  = seq_hit(rmc_seq_a, rmc_len, hist_nxt);
	wire hit_b  = seq_hit(rmc_seq_b, rmc_len, hist_nxt);
	wire hit_c  = seq_hit(bond_seq_a, bond_len, hist_nxt);
	wire hit_d  = seq_hit(bond_seq_b, bond_len, hist_nxt);
	wire rmc_ok  = (hist_cnt_r >= {1'b0, rmc_len}); // [RULE_02]
	wire bond_ok = (hist_cnt_r >= {1'b0, bond_len});
	wire rmc_hit = ev && rmc_en && rmc_ok
		&& (hit_a || (rmc_two_en && hit_b)); // [RULE_01] [RULE_03]
	wire bond_hit = ev && bond_en && bond_ok
		&& (hit_c || (bond_two_en && hit_d)); // [RULE_13]

	// correction decisions
	wire rmc_rm  = rmc_hit && (occ > BUF_NOMINAL); // [RULE_16]
	wire rmc_ins = rmc_hit && (occ < BUF_NOMINAL); // [RULE_16]
	wire bond_adj = bond_hit && !rmc_hit && bond_slip_req; // [RULE_14]
	wire bond_rm  = bond_adj && bond_slip_remove
		&& (skew_r != SKEW_MIN) && (occ > {4'h0, bond_len}); // [RULE_15]
	wire bond_ins = bond_adj && !bond_slip_remove
		&& (skew_r != SKEW_MAX); // [RULE_15]
	wire rm  = rmc_rm || bond_rm;
	wire ins = rmc_ins || bond_ins;
	wire [1:0] seq_len = rmc_hit ? rmc_len : bond_len;

	// write side: drop rewinds the earlier symbols of the occurrence,
	// insert replays the whole occurrence from history
	wire       replay  = (rep_cnt_r != 3'h0) && !ev;
	wire [2:0] rep_dec = rep_cnt_r - 3'h1;
	wire [1:0] rep_idx = rep_dec[1:0];
	wire       wr_want = (ev && !rm) || replay;
	wire       wr_en   = wr_want && !full;
	wire rmcm_sym_t wr_data = ev ? sym_s2_r : hist_r[rep_idx];
	wire [5:0] wptr_nxt = rm ? 6'(wptr_r - {4'h0, seq_len}) // [RULE_17]
		: 6'(wptr_r + {5'h00, wr_en});
	wire [2:0] rep_nxt = ins ? 3'({1'b0, seq_len} + 3'h1) // [RULE_17]
		: (replay ? rep_dec : rep_cnt_r);
	wire [2:0] hcnt_inc = (hist_cnt_r == HIST_FULL) ? hist_cnt_r
		: 3'(hist_cnt_r + 3'h1);
	// history restarts after a correction so one occurrence acts once
	wire [2:0] hist_cnt_nxt = !ev ? hist_cnt_r
		: ((rm || ins) ? 3'h0 : hcnt_inc);
	wire signed [3:0] skew_nxt = bond_rm ? 4'(skew_r - 4'sh1)
		: (bond_ins ? 4'(skew_r + 4'sh1) : skew_r);

	// read side
	wire rd_issue = (!out_valid_r || rd_ready) && !empty;
	wire out_valid_nxt = rd_issue ? 1'b1 : (rd_ready ? 1'b0 : out_valid_r);
	wire [5:0] rptr_nxt = 6'(rptr_r + {5'h00, rd_issue});

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			hist_r       <= '0;
			hist_cnt_r   <= 3'h0;
			rep_cnt_r    <= 3'h0;
			wptr_r       <= 6'h00;
			rptr_r       <= 6'h00;
			out_valid_r  <= 1'b0;
			skew_r       <= 4'sh0;
			occ_r        <= 6'h00;
			rmc_removed  <= 1'b0;
			rmc_inserted <= 1'b0;
			bond_match   <= 1'b0;
			overflow     <= 1'b0;
		end
		else
		begin
			if (ev)
				hist_r <= hist_nxt;
			hist_cnt_r   <= hist_cnt_nxt;
			rep_cnt_r    <= rep_nxt;
			wptr_r       <= wptr_nxt;
			rptr_r       <= rptr_nxt;
			out_valid_r  <= out_valid_nxt;
			skew_r       <= skew_nxt;
			occ_r        <= 6'(wptr_nxt - rptr_nxt);
			rmc_removed  <= rmc_rm;
			rmc_inserted <= rmc_ins;
			bond_match   <= bond_hit;
			overflow     <= wr_want && full;
		end
	end

	logic [SYM_BITS-1:0] mem_q;

	rmcm_mem #(
		.W  (SYM_BITS),
		.AW (BUF_AW)
	) u_mem (
		.clock   (clock),
		.wr_en   (wr_en),
		.wr_addr (wptr_r[BUF_AW-1:0]),
		.wr_data (wr_data),
		.rd_en   (rd_issue),
		.rd_addr (rptr_r[BUF_AW-1:0]),
		.rd_data (mem_q)
	);

	assign rd_sym    = rmcm_sym_t'(mem_q);
	assign rd_valid  = out_valid_r;
	assign occupancy = occ_r;
	assign bond_skew = skew_r;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_corr_needs_en: assert property ((rmc_rm || rmc_ins) |-> rmc_en) // [RULE_01]
		else $error("correction without enable");
	a_drop_above_nom: assert property (rmc_rm |-> occ > BUF_NOMINAL) // [RULE_16]
		else $error("drop at or below nominal");
	a_ins_below_nom: assert property (rmc_ins |-> occ < BUF_NOMINAL) // [RULE_16]
		else $error("insert at or above nominal");
	a_ins_replay_len: assert property ( // [RULE_17]
		ins |=> rep_cnt_r == 3'($past(seq_len)) + 3'h1)
		else $error("replay length differs from sequence");
	a_drop_rewind: assert property ( // [RULE_17]
		rm |=> wptr_r == 6'($past(wptr_r) - {4'h0, $past(seq_len)}))
		else $error("drop rewind wrong");
	a_second_seq_gate: assert property ( // [RULE_03]
		(ev && rmc_en && rmc_ok && !rmc_two_en && !hit_a) |-> !rmc_hit)
		else $error("second sequence used while off");
	a_skew_bound: assert property ( // [RULE_15]
		skew_r <= SKEW_MAX && skew_r >= SKEW_MIN)
		else $error("bonding skew out of range");
	a_match_pulse: assert property ( // [RULE_16]
		rmc_hit |=> rmc_removed == ($past(occ) > BUF_NOMINAL)
		&& rmc_inserted == ($past(occ) < BUF_NOMINAL))
		else $error("correction flag not tied to fill level");
	a_out_hold: assert property ( // [RULE_01]
		(rd_valid && !rd_ready) |=> rd_valid && $stable(rd_sym))
		else $error("output changed while stalled");

	c_drop:   cover property (rmc_rm);
	c_insert: cover property (rmc_ins ##1 replay);
	c_bond:   cover property (bond_rm || bond_ins);
	c_second: cover property (rmc_hit && !hit_a);
endmodule : rmcm_top

// ==== tb/rmcm_tx_model.sv ====
/*
 * far-end transmitter model: one symbol per link clock pulse.
 * assumes the bench calls send; the link clock rests low between symbols.
 */
`timescale 1ns/1ps
module rmcm_tx_model
	import rmcm_pkg::*;
(
	output logic                link_clk,
	output rmcm_pkg::rmcm_sym_t link_sym
);
	import rmcm_pkg::*;

	initial
	begin
		link_clk = 1'b0;
		link_sym = '0;
	end

	// symbol changes while the clock is low, off the core clock phase
	task automatic send(input rmcm_sym_t s);
		link_sym = s;
		#167;
		link_clk = 1'b1;
		#160;
		link_clk = 1'b0;
		// released line shows the inverse of the last symbol
		link_sym = ~s;
	endtask : send
endmodule : rmcm_tx_model

// ==== tb/tb.sv ====
/*
 * bench for the rate-match matcher: symbols from the transmitter model,
 * pulses counted, buffer drained and compared at the end.
 * assumes one core clock and a link clock of 327 ns or more from the model.
 */
`timescale 1ns/1ps
module tb;
	import rmcm_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, link_clk, rd_ready = 1'b0;
	logic rmc_en = 1'b0, rmc_two_en = 1'b0, bond_en = 1'b0;
	logic bond_two_en = 1'b0, bond_slip_req = 1'b0, bond_slip_remove = 1'b0;
	logic rd_valid, rmc_removed, rmc_inserted, bond_match, overflow;
	logic [1:0] rmc_len = 2'h0, bond_len = 2'h0;
	rmcm_seq_t rmc_seq_a = '0, rmc_seq_b = '0, bond_seq_a = '0, bond_seq_b = '0;
	rmcm_sym_t link_sym, rd_sym;
	rmcm_sym_t got[$];
	logic [5:0] occupancy;
	logic signed [3:0] bond_skew;
	int num_errors = 0, n_tests = 0, n_ins = 0, n_rem = 0, n_bond = 0, eo = 0;
	int n_ovf = 0;

	always #20 clock = ~clock;

	rmcm_tx_model i_rmcm_tx_model (.link_clk(link_clk), .link_sym(link_sym));
	rmcm_top i_rmcm_top (.clock(clock), .reset_n(reset_n),
		.link_clk(link_clk), .link_sym(link_sym), .rmc_en(rmc_en),
		.rmc_two_en(rmc_two_en), .rmc_len(rmc_len), .rmc_seq_a(rmc_seq_a),
		.rmc_seq_b(rmc_seq_b), .bond_en(bond_en), .bond_two_en(bond_two_en),
		.bond_len(bond_len), .bond_seq_a(bond_seq_a), .bond_seq_b(bond_seq_b),
		.bond_slip_req(bond_slip_req), .bond_slip_remove(bond_slip_remove),
		.rd_ready(rd_ready), .rd_valid(rd_valid), .rd_sym(rd_sym),
		.occupancy(occupancy), .rmc_removed(rmc_removed),
		.rmc_inserted(rmc_inserted), .bond_match(bond_match),
		.bond_skew(bond_skew), .overflow(overflow));

	always @(posedge clock)
	begin
		n_ins <= n_ins + (rmc_inserted === 1'b1);
		n_rem <= n_rem + (rmc_removed === 1'b1);
		n_bond <= n_bond + (bond_match === 1'b1);
		n_ovf <= n_ovf + (overflow === 1'b1);
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			got.push_back(rd_sym);
	end

	task automatic check(input string name, input logic [9:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic lnk(input logic [7:0] d, input logic k, inv);
		i_rmcm_tx_model.send({d, k, inv});
		repeat (6) @(posedge clock);
		#1;
	endtask : lnk

	task automatic snd(input logic [7:0] d, input logic k, inv, input int dl);
		lnk(d, k, inv);
		eo = eo + dl;
		// first word parks in the output stage, outside the count
		check("occupancy", 10'(occupancy), 10'(eo - 1));
	endtask : snd

	task automatic t_insert;
		@(posedge clock);
		rmc_en <= 1'b1;
		rmc_seq_a <= {{3{11'h7f8}}, REF_RMC_SYM, 3'b100};
		snd(REF_RMC_SYM, 1'b1, 1'b0, 2);
		check("inserted", 10'(n_ins), 10'h1);
		snd(REF_RMC_SYM, 1'b0, 1'b0, 1);
		check("k flag", 10'(n_ins), 10'h1);
	endtask : t_insert

	task automatic t_remove;
		for (int i = 0; i < 15; i++)
			snd(8'(i), 1'b0, 1'b0, 1);
		snd(REF_RMC_SYM, 1'b1, 1'b0, 0);
		check("removed", 10'(n_rem), 10'h1);
		snd(REF_RMC_SYM, 1'b1, 1'b1, 1);
		@(posedge clock);
		rmc_seq_a[0].inv_ok <= 1'b1;
		snd(REF_RMC_SYM, 1'b1, 1'b1, 0);
		check("inverted", 10'(n_rem), 10'h2);
	endtask : t_remove

	task automatic t_two;
		@(posedge clock);
		rmc_seq_b <= {{3{11'h7f8}}, 8'h55, 3'b000};
		snd(8'h55, 1'b0, 1'b0, 1);
		@(posedge clock);
		rmc_two_en <= 1'b1;
		snd(8'h55, 1'b0, 1'b0, 0);
		check("second seq", 10'(n_rem), 10'h3);
		@(posedge clock);
		rmc_two_en <= 1'b0;
		rmc_len <= 2'h1;
		rmc_seq_a[1] <= 11'h001;
		snd(REF_RMC_SYM, 1'b1, 1'b0, 1);
		snd(8'ha5, 1'b0, 1'b0, -1);
		check("wildcard", 10'(n_rem), 10'h4);
	endtask : t_two

	task automatic t_bond;
		@(posedge clock);
		rmc_len <= 2'h0;
		bond_en <= 1'b1;
		bond_seq_a <= {{3{11'h7f8}}, REF_BOND_SYM, 3'b100};
		bond_seq_b <= {{3{11'h7f8}}, 8'h3c, 3'b100};
		lnk(REF_BOND_SYM, 1'b1, 1'b0);
		check("bond match", 10'(n_bond), 10'h1);
		check("bond skew", 10'(bond_skew), 10'h0);
		@(posedge clock);
		bond_slip_req <= 1'b1;
		lnk(REF_BOND_SYM, 1'b1, 1'b0);
		check("bond skew", 10'(bond_skew), 10'h1);
		@(posedge clock);
		bond_two_en <= 1'b1;
		bond_slip_remove <= 1'b1;
		lnk(8'h3c, 1'b1, 1'b0);
		check("bond skew", 10'(bond_skew), 10'h0);
		check("bond match", 10'(n_bond), 10'h3);
	endtask : t_bond

	// ten fillers reach full, the eleventh is lost
	task automatic t_full;
		@(posedge clock);
		bond_slip_req <= 1'b0;
		for (int i = 0; i < 11; i++)
			lnk(8'h80 + 8'(i), 1'b0, 1'b0);
		check("full", 10'(occupancy), 10'h020);
		check("overflow", 10'(n_ovf), 10'h001);
	endtask : t_full

	task automatic t_drain;
		int i;
		@(posedge clock);
		bond_slip_req <= 1'b0;
		rd_ready <= 1'b1;
		for (i = 0; i < 200 && !(i > 4 && occupancy === 6'h0
			&& rd_valid === 1'b0); i++)
			@(posedge clock);
		if (i == 200)
			num_errors++;
		check("first", 10'(got[0]), {REF_RMC_SYM, 2'b10});
		check("repeat", 10'(got[1]), {REF_RMC_SYM, 2'b10});
		check("third", 10'(got[2]), {REF_RMC_SYM, 2'b00});
		check("fourth", 10'(got[3]), 10'h000);
		check("count", 10'(got.size()), 10'h021);
		check("after drop", 10'(got[19]), {8'h55, 2'b00});
		check("bond repeat", 10'(got[22]), {REF_BOND_SYM, 2'b10});
		check("last", 10'(got[32]), {8'h89, 2'b00});
	endtask : t_drain

	task automatic summarize;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		#1;
		check("rd_valid", 10'(rd_valid), 10'h0);
		t_insert();
		t_remove();
		t_two();
		t_bond();
		t_full();
		t_drain();
		summarize();
	end
endmodule : tb
